/* File: inc/dsj_pkg.sv */
// Package for the skip/jump/increment decode and execute block
package dsj_pkg;

    // ------------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_DSNZ_HI   = 8'h26;
    localparam logic [7:0] OPC_INCREMENT_FILE_OP_HI   = 8'h14;
    localparam logic [6:0] OPC_DEST_MASK = 7'h7F;
    localparam logic [2:0] OPC_JUMP_HI   = 3'h6;
    localparam int         DEST_BIT      = 8;
    localparam int         JUMP_MSB      = 15;
    localparam int         JUMP_LSB      = 13;
    localparam int         FILE_AW       = 8;
    localparam int         DATA_W        = 8;
    localparam int         PC_W          = 16;
    localparam int         LIT_W         = 13;
    localparam int         NIB_W         = 4;

    // ------------------------------------------------------------------
    // Reset values and increment constants
    // ------------------------------------------------------------------
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [7:0]  ONE_BYTE  = 8'h01;
    localparam logic [15:0] PC_STEP   = 16'h0001;

    // Phase within an instruction cycle
    typedef enum logic [1:0] {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_EXECUTE = 2'b10,
        PH_WRITE   = 2'b11
    } dsj_phase_e;

    // Arithmetic flags
    typedef struct packed {
        logic signed_wrap_flag;
        logic carry;
        logic digit_carry;
        logic zero;
    } dsj_flags_s;

    // File register write request
    typedef struct packed {
        logic             en;
        logic [7:0]       addr;
        logic [7:0]       data;
    } dsj_fwr_s;

endpackage

/* File: hdl/dsj_core.sv */
// Decode/execute logic for decrement-skip, absolute jump and increment
// Contract
// - Decrement-skip-nonzero decrements, flags untouched
// - Destination bit picks working or file register
// - Nonzero decrement result squashes next word
// - Jump loads 13-bit literal into low PC
// - Jump refreshes PC high latch fields
// - Jump always takes two instruction cycles
// - Jump keeps PC page bits 15:13
// - Increment adds one, updates four flags
// - Increment of FF wraps, sets zero, carry
`timescale 1ns/1ps
module dsj_core (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    // Instruction and file read data
    input  wire logic [15:0]           instr_i,
    input  wire logic [7:0]            file_rdata_i,
    // File register access
    output logic      [7:0]            file_raddr_o,
    output dsj_pkg::dsj_fwr_s          file_wr_o,
    // Architectural state
    output logic      [15:0]           pc_o,
    output logic      [7:0]            pc_high_latch_o,
    output logic      [7:0]            working_register_o,
    output dsj_pkg::dsj_flags_s        flags_o,
    // Timing status
    output dsj_pkg::dsj_phase_e        phase_o,
    output logic                       squash_o
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic is_dsnz;
    logic is_increment_file_op;
    logic is_jump;
    logic dest_file;
    always_comb begin
        is_dsnz   = instr_i[15:9] == dsj_pkg::OPC_DSNZ_HI[7:1];
        is_increment_file_op   = instr_i[15:9] == dsj_pkg::OPC_INCREMENT_FILE_OP_HI[7:1];
        is_jump   = instr_i[15:13] == dsj_pkg::OPC_JUMP_HI;
        dest_file = instr_i[dsj_pkg::DEST_BIT];
    end

    // ------------------------------------------------------------------
    // Phase and execute state
    // ------------------------------------------------------------------
    dsj_pkg::dsj_phase_e phase_q, phase_d;
    logic [15:0]         pc_q, pc_d;
    logic [7:0]          lat_q, lat_d;
    logic [7:0]          working_register_q, working_register_d;
    logic [7:0]          opnd_q, opnd_d;
    logic [7:0]          res_q, res_d;
    dsj_pkg::dsj_flags_s flg_q, flg_d;
    dsj_pkg::dsj_fwr_s   fwr_q, fwr_d;
    logic                sq_q, sq_d;
    logic [7:0]          raddr_q, raddr_d;
    logic [8:0]          sum;
    logic [4:0]          nib;
    logic                squash_now;

    always_comb begin
        phase_d = phase_q;
        pc_d    = pc_q;
        lat_d   = lat_q;
        working_register_d  = working_register_q;
        opnd_d  = opnd_q;
        res_d   = res_q;
        flg_d   = flg_q;
        fwr_d   = '0;
        sq_d    = sq_q;
        raddr_d = instr_i[7:0];
        sum     = 9'h000;
        nib     = 5'h00;
        // Squashed word is executed as a forced NOP
        squash_now = sq_q;
        case (phase_q)
            dsj_pkg::PH_DECODE: begin
                phase_d = dsj_pkg::PH_READ;
            end
            dsj_pkg::PH_READ: begin
                opnd_d  = file_rdata_i;
                phase_d = dsj_pkg::PH_EXECUTE;
            end
            dsj_pkg::PH_EXECUTE: begin
                phase_d = dsj_pkg::PH_WRITE;
                if (!squash_now && is_dsnz) begin
                    res_d = opnd_q - dsj_pkg::ONE_BYTE;
                end else if (!squash_now && is_increment_file_op) begin
                    sum   = {1'b0, opnd_q} + {1'b0, dsj_pkg::ONE_BYTE};
                    res_d = sum[7:0];
                end
            end
            dsj_pkg::PH_WRITE: begin
                phase_d = dsj_pkg::PH_DECODE;
                pc_d    = pc_q + dsj_pkg::PC_STEP;
                sq_d    = 1'b0;
                if (!squash_now) begin
                    if (is_dsnz || is_increment_file_op) begin
                        if (dest_file) begin
                            fwr_d.en   = 1'b1;
                            fwr_d.addr = instr_i[7:0];
                            fwr_d.data = res_q;
                        end else begin
                            working_register_d = res_q;
                        end
                    end
                    if (is_dsnz && res_q != dsj_pkg::BYTE_RST) begin
                        sq_d = 1'b1;
                    end
                    if (is_increment_file_op) begin
                        sum = {1'b0, opnd_q} + {1'b0, dsj_pkg::ONE_BYTE};
                        nib = {1'b0, opnd_q[3:0]} + 5'h01;
                        flg_d.carry       = sum[8];
                        flg_d.zero        = sum[7:0] == dsj_pkg::BYTE_RST;
                        flg_d.digit_carry = nib[4];
                        flg_d.signed_wrap_flag = ~opnd_q[7] & sum[7];
                    end
                    if (is_jump) begin
                        // Upper page bits stay, low 13 replaced
                        pc_d = {pc_q[dsj_pkg::JUMP_MSB:dsj_pkg::JUMP_LSB],
                                instr_i[dsj_pkg::LIT_W-1:0]};
                        lat_d = {pc_q[dsj_pkg::JUMP_MSB:dsj_pkg::JUMP_LSB],
                                 instr_i[12:8]};
                        sq_d  = 1'b1;
                    end
                end
            end
            default: phase_d = dsj_pkg::PH_DECODE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q <= dsj_pkg::PH_DECODE;
            pc_q    <= dsj_pkg::PC_RST;
            lat_q   <= dsj_pkg::BYTE_RST;
            working_register_q  <= dsj_pkg::BYTE_RST;
            opnd_q  <= dsj_pkg::BYTE_RST;
            res_q   <= dsj_pkg::BYTE_RST;
            flg_q   <= '0;
            fwr_q   <= '0;
            sq_q    <= 1'b0;
            raddr_q <= dsj_pkg::BYTE_RST;
        end else begin
            phase_q <= phase_d;
            pc_q    <= pc_d;
            lat_q   <= lat_d;
            working_register_q  <= working_register_d;
            opnd_q  <= opnd_d;
            res_q   <= res_d;
            flg_q   <= flg_d;
            fwr_q   <= fwr_d;
            sq_q    <= sq_d;
            raddr_q <= raddr_d;
        end
    end

    always_comb begin
        file_raddr_o       = raddr_q;
        file_wr_o          = fwr_q;
        pc_o               = pc_q;
        pc_high_latch_o    = lat_q;
        working_register_o = working_register_q;
        flags_o            = flg_q;
        phase_o            = phase_q;
        squash_o           = sq_q;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic wr_ph;
    always_comb wr_ph = phase_q == dsj_pkg::PH_WRITE && !sq_q;

    property p_dsnz_flags;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_ph && is_dsnz) |=> $stable(flg_q);
    endproperty
    a_dsnz_flags: assert property (p_dsnz_flags)
        else $error("dec flags moved");

    property p_dest_file;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_ph && (is_dsnz || is_increment_file_op) && dest_file)
            |=> fwr_q.en && fwr_q.data == $past(res_q) && $stable(working_register_q);
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("file dest bad");

    property p_dest_working_register;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_ph && (is_dsnz || is_increment_file_op) && !dest_file)
            |=> !fwr_q.en && working_register_q == $past(res_q);
    endproperty
    a_dest_working_register: assert property (p_dest_working_register)
        else $error("working_register dest bad");

    property p_skip;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_ph && is_dsnz && res_q != dsj_pkg::BYTE_RST) |=> sq_q [*4];
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip missing");

    property p_jump;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_ph && is_jump) |=> pc_q[12:0] == $past(instr_i[12:0])
            && pc_q[15:13] == $past(pc_q[15:13])
            && lat_q == {$past(pc_q[15:13]), $past(instr_i[12:8])} && sq_q;
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump wrong");

    property p_jump_two;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_ph && is_jump) |=> sq_q ##4 !sq_q;
    endproperty
    a_jump_two: assert property (p_jump_two)
        else $error("jump len");

    property p_inc_wrap;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_ph && is_increment_file_op && opnd_q == 8'hFF)
            |=> flg_q.zero && flg_q.carry && res_q == 8'h00;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap)
        else $error("wrap flags");

    property p_squash;
        @(posedge clk_sys_i) disable iff (rst_i)
        (phase_q == dsj_pkg::PH_WRITE && sq_q)
            |=> !fwr_q.en && $stable(flg_q) && pc_q == $past(pc_q) + 16'h0001;
    endproperty
    a_squash: assert property (p_squash)
        else $error("squash leak");

    c_skip:  cover property (@(posedge clk_sys_i) wr_ph && is_dsnz);
    c_jump:  cover property (@(posedge clk_sys_i) wr_ph && is_jump);
    c_increment_file_op:  cover property (@(posedge clk_sys_i) wr_ph && is_increment_file_op);

endmodule // dsj_core

/* File: bench/dsj_tb.sv */
// Self-checking testbench for the skip/jump/increment block
`timescale 1ns/1ps
module tb;
    // ----------------------------------------------------------------
    // Signals and expected state
    // ----------------------------------------------------------------
    logic                clk_sys_i    = 1'b0;
    logic                rst_i        = 1'b1;
    logic [15:0]         instr_i      = 16'h0000;
    logic [7:0]          file_rdata_i = 8'h00;
    logic [7:0]          file_raddr_o;
    dsj_pkg::dsj_fwr_s   file_wr_o;
    logic [15:0]         pc_o;
    logic [7:0]          pc_high_latch_o;
    logic [7:0]          working_register_o;
    dsj_pkg::dsj_flags_s flags_o;
    dsj_pkg::dsj_phase_e phase_o;
    logic                squash_o;
    int                  errors     = 0;
    int                  n_compared = 0;
    int                  cycles     = 0;
    logic [15:0]         lfsr       = 16'h001E;
    logic [15:0]         e_pc       = 16'h0000;
    logic [7:0]          e_lat      = 8'h00;
    logic [7:0]          e_w        = 8'h00;
    logic [7:0]          e_ra       = 8'h00;
    logic                e_sq       = 1'b0;
    dsj_pkg::dsj_flags_s e_fl       = '0;
    dsj_pkg::dsj_fwr_s   e_wr       = '0;

    dsj_core dut_u (
        .clk_sys_i          (clk_sys_i),
        .rst_i              (rst_i),
        .instr_i            (instr_i),
        .file_rdata_i       (file_rdata_i),
        .file_raddr_o       (file_raddr_o),
        .file_wr_o          (file_wr_o),
        .pc_o               (pc_o),
        .pc_high_latch_o    (pc_high_latch_o),
        .working_register_o (working_register_o),
        .flags_o            (flags_o),
        .phase_o            (phase_o),
        .squash_o           (squash_o)
    );

    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // Generous ceiling, the run needs about 950 cycles
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Flags after incrementing v: wrap, carry, digit carry, zero
    function automatic dsj_pkg::dsj_flags_s inc_flags(input logic [7:0] v);
        return {v == 8'h7F, v == 8'hFF, v[3:0] == 4'hF, v == 8'hFF};
    endfunction

    task automatic final_report();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t: %s mismatch", $time, what);
        end
    endtask

    task automatic check();
        cmp(pc_o === e_pc, "pc");
        cmp(pc_high_latch_o === e_lat, "high latch");
        cmp(working_register_o === e_w, "working reg");
        cmp(flags_o === e_fl, "flags");
        cmp(squash_o === e_sq, "squash");
        cmp(file_wr_o.en === e_wr.en, "write enable");
        if (e_wr.en) cmp(file_wr_o === e_wr, "write");
        cmp(file_raddr_o === e_ra, "read address");
        cmp(phase_o === dsj_pkg::PH_DECODE, "phase");
    endtask

    // Called at the edge that starts phase 0; checks the previous word
    task automatic run(input logic [15:0] ins, input logic [7:0] fd);
        logic [7:0] r;
        logic       hit;
        instr_i      <= ins;
        file_rdata_i <= fd;
        @(negedge clk_sys_i);
        check();
        hit  = 1'b0;
        r    = 8'h00;
        e_ra = ins[7:0];
        e_wr = '0;
        if (e_sq) begin
            e_sq = 1'b0;
            e_pc = e_pc + dsj_pkg::PC_STEP;
        end else if (ins[15:13] == dsj_pkg::OPC_JUMP_HI) begin
            e_lat = {e_pc[15:13], ins[12:8]};
            e_pc  = {e_pc[15:13], ins[12:0]};
            e_sq  = 1'b1;
        end else begin
            e_pc = e_pc + dsj_pkg::PC_STEP;
            if (ins[15:9] == dsj_pkg::OPC_DSNZ_HI[7:1]) begin
                r    = fd - 8'h01;
                e_sq = (r != 8'h00);
                hit  = 1'b1;
            end else if (ins[15:9] == dsj_pkg::OPC_INCREMENT_FILE_OP_HI[7:1]) begin
                r    = fd + 8'h01;
                e_fl = inc_flags(fd);
                hit  = 1'b1;
            end
        end
        if (hit && ins[dsj_pkg::DEST_BIT]) begin
            e_wr = {1'b1, ins[7:0], r};
        end else if (hit) begin
            e_w = r;
        end
        repeat (4) @(posedge clk_sys_i);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] ins;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        run(16'h1510, 8'hFF);
        run(16'h1420, 8'hFF);
        run(16'h1433, 8'h7F);
        run(16'h1444, 8'h0F);
        run(16'h2655, 8'h01);
        run(16'h2766, 8'h00);
        run(16'h1577, 8'h10);
        run(16'h2680, 8'h05);
        run(16'hC123, 8'h00);
        // Land near the page end so the NOPs carry PC into page 1
        run(16'hDFFE, 8'h00);
        for (int i = 0; i < 20; i++) run(16'h0000, 8'h00);
        run(16'hD2AB, 8'h00);
        run(16'hC000, 8'h00);
        for (int i = 0; i < 200; i++) begin
            lfsr = nxt(lfsr);
            case (lfsr[1:0])
                2'h0: ins = {7'h13, lfsr[2], lfsr[15:8]};
                2'h1: ins = {7'h0A, lfsr[2], lfsr[15:8]};
                2'h2: ins = {4'hC, lfsr[15:4]};
                default: ins = {8'h00, lfsr[15:8]};
            endcase
            lfsr = nxt(lfsr);
            run(ins, lfsr[11:4]);
        end
        run(16'h0000, 8'h00);
        final_report();
    end
endmodule // tb
